// file: pfc_pkg.sv
// constants, field layouts and carrier types of the pulser control block
// assumes a 20 MHz system clock; shared by the control top, its checker and its bench
package pfc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned AUTOCLR_TIME_US = 6000;
  localparam int unsigned AUTOCLR_CYC = AUTOCLR_TIME_US * CLK_PER_US;
  localparam int unsigned PWRUP_TIME_S = 5;
  localparam int unsigned PWRUP_CYC = PWRUP_TIME_S * CLK_HZ;
  localparam int unsigned OC_INHIBIT_TIME_US = 6500;
  localparam int unsigned OC_INHIBIT_CYC = OC_INHIBIT_TIME_US * CLK_PER_US;
  localparam int unsigned RATE_MAX_KHZ = 250;
  localparam int unsigned RATE_MIN_PERIOD_CYC = CLK_HZ / (RATE_MAX_KHZ * 1000);
  localparam int unsigned DEBOUNCE_TIME_US = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_TIME_US * CLK_PER_US;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
  localparam int unsigned CTRL_ALLOW_BIT = 0;
  localparam logic CTRL_ALLOW_RST = 1'h1;
  localparam int unsigned EVT_W = 5;
  localparam logic [EVT_W-1:0] IRQ_MASK_RST = 5'h00;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic panel_press;
    logic enable_n;
    logic invert_n;
    logic remote_n;
    logic interlock_n;
    logic autoclr_n;
  } pfc_pins_type;
  localparam int unsigned PINS_W = $bits(pfc_pins_type);
  // pulled-up pins idle high, the panel button idles released
  localparam logic [PINS_W-1:0] PINS_IDLE = 6'h1F;

  typedef struct packed {
    logic overcurrent;
    logic gate;
  } pfc_fast_type;
  localparam int unsigned FAST_W = $bits(pfc_fast_type);
  localparam logic [FAST_W-1:0] FAST_IDLE = 2'h0;

  typedef struct packed {
    logic rate_err;
    logic overcurrent;
    logic enabled;
    logic fault_clr;
    logic fault_set;
  } pfc_evt_type;

  typedef struct packed {
    logic gate_seen;
    logic interlock_ok;
    logic remote_mode;
    logic rate_err;
    logic oc_inhibit;
    logic pwrup_pending;
    logic fault_latched;
    logic out_enabled;
  } pfc_state_type;

  typedef enum logic [1:0] {
    ST_FAULT = 2'b00,
    ST_IDLE = 2'b01,
    ST_ENABLED = 2'b10
  } pfc_mode_type;

endpackage : pfc_pkg

// file: pfc_in_sync.sv
// three-stage synchroniser with agreement filter and debounce count
// assumes inputs are asynchronous to i_sys_clk
`timescale 1ns/10ps
module pfc_in_sync
#(
  parameter int unsigned W = 1,
  parameter int unsigned DEB_CYC = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  localparam int unsigned CW = $clog2(DEB_CYC + 1);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [CW-1:0] cnt [W];

  // a new level is only believed once stages two and three agree
  wire [W-1:0] agree_new = ~(s2 ^ s3) & (s3 ^ o_sync);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      o_sync <= RST_VAL;
      for (int i = 0; i < W; i++)
        cnt[i] <= '0;
    end
    else if (i_ce)
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++)
      begin
        if (!agree_new[i])
          cnt[i] <= '0;
        else if (cnt[i] == CW'(DEB_CYC - 1))
        begin
          o_sync[i] <= s3[i];
          cnt[i] <= '0;
        end
        else
          cnt[i] <= cnt[i] + 1'h1;
      end
    end
  end

endmodule : pfc_in_sync

// file: pfc_hold_timer.sv
// saturating run timer: o_done holds while i_run has lasted LIMIT cycles
// assumes i_run comes from logic on the same clock
`timescale 1ns/10ps
module pfc_hold_timer
#(
  parameter int unsigned LIMIT = 16
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_run,
  output logic o_done
);

  localparam int unsigned CW = $clog2(LIMIT + 1);

  logic [CW-1:0] cnt;

  wire at_limit = (cnt == CW'(LIMIT));

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      cnt <= '0;
    else if (i_ce)
    begin
      if (!i_run)
        cnt <= '0;
      else if (!at_limit)
        cnt <= cnt + 1'h1;
    end
  end

  assign o_done = i_run & at_limit;

endmodule : pfc_hold_timer

// file: pfc_ctrl.sv
// pulser enable and fault control with an AHB-Lite register slave
// assumes rear-panel pins, panel button, gate and overcurrent are asynchronous
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps

// Function
// - unconnected remote pins read inactive high
// - remote select low blocks panel enable
// - enable, interlock, invert, self-clear always active
// - enable rising edge clears fault or enables
// - invert low inverts the gate internally
// - no enable unless interlock held low
// - interlock loss and overcurrent raise fault
// - self-clear low clears fault after 6 ms
// - self-clear high keeps fault until manual clear
// - power-up starts faulted, output disabled
// - gate present clears power-up fault in 5 s
// - enable during power-up fault is ignored
// - output follows gate width and rate
// - over 15 A: indicator, inhibit about 6.5 ms
// - gate above 250 kHz: indicator, inhibit (code also trips at exactly 250 kHz, an 80-cycle period)
// - gate high selects high supply, else low
module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int unsigned AUTOCLR_CYC_P = AUTOCLR_CYC,
  parameter int unsigned PWRUP_CYC_P = PWRUP_CYC,
  parameter int unsigned OC_INHIBIT_CYC_P = OC_INHIBIT_CYC,
  parameter int unsigned RATE_MIN_PERIOD_CYC_P = RATE_MIN_PERIOD_CYC,
  parameter int unsigned DEBOUNCE_CYC_P = DEBOUNCE_CYC
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // rear-panel control pins, active low, pulled up at the pad
  input wire logic i_enable_n,
  input wire logic i_invert_n,
  input wire logic i_remote_n,
  input wire logic i_interlock_n,
  input wire logic i_autoclr_n,
  // front-panel enable button, high while pressed
  input wire logic i_panel_press,
  // gate input and overcurrent comparator
  input wire logic i_gate,
  input wire logic i_overcurrent,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // output stage and indicators
  output logic o_drive_high,
  output logic o_drive_low,
  output logic o_led_enabled,
  output logic o_led_gated,
  output logic o_led_overcurrent,
  output logic o_led_rate_err,
  output logic o_fault,
  output logic o_irq
);

  localparam int unsigned OCW = $clog2(OC_INHIBIT_CYC_P + 1);
  localparam int unsigned PW = $clog2(RATE_MIN_PERIOD_CYC_P + 1);

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  pfc_pins_type pins;
  pfc_fast_type fast;
  // slow control pins get the full debounce; their reset value is idle
  pfc_in_sync #(.W(PINS_W), .DEB_CYC(DEBOUNCE_CYC_P), .RST_VAL(PINS_IDLE)) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({i_panel_press, i_enable_n, i_invert_n, i_remote_n, i_interlock_n, i_autoclr_n}),
    .o_sync(pins)
  );

  // gate and comparator are not debounced so short pulses survive
  pfc_in_sync #(.W(FAST_W), .DEB_CYC(1), .RST_VAL(FAST_IDLE)) u_fast_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({i_overcurrent, i_gate}),
    .o_sync(fast)
  );

  // ****************************************************************
  // edges and levels
  // ****************************************************************
  logic en_prev;
  logic pb_prev;
  logic il_prev;
  logic oc_prev;
  logic gate_prev;

  wire il_ok = ~pins.interlock_n;
  wire remote_mode = ~pins.remote_n;
  wire autoclr_on = ~pins.autoclr_n;
  wire remote_rise = pins.enable_n & ~en_prev;
  wire panel_rise = pins.panel_press & ~pb_prev;
  wire panel_edge = panel_rise & ~remote_mode;
  wire enable_edge = remote_rise | panel_edge;
  wire il_lost = il_prev & ~il_ok;
  wire oc_rise = fast.overcurrent & ~oc_prev;
  wire gate_rise = fast.gate & ~gate_prev;
  wire fault_evt = il_lost | oc_rise;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      en_prev <= 1'h1;
      pb_prev <= 1'h0;
      il_prev <= 1'h0;
      oc_prev <= 1'h0;
      gate_prev <= 1'h0;
    end
    else if (i_ce)
    begin
      en_prev <= pins.enable_n;
      pb_prev <= pins.panel_press;
      il_prev <= il_ok;
      oc_prev <= fast.overcurrent;
      gate_prev <= fast.gate;
    end
  end

  // ****************************************************************
  // fault timers
  // ****************************************************************
  pfc_mode_type mode;
  pfc_mode_type next_mode;
  logic pwrup_pending;
  logic gate_seen;
  logic auto_done;
  logic pwrup_done;

  // a fresh fault restarts the self-clear wait
  wire auto_run = (mode == ST_FAULT) & ~pwrup_pending & autoclr_on & ~fault_evt;
  wire pwrup_run = pwrup_pending & gate_seen;
  pfc_hold_timer #(.LIMIT(AUTOCLR_CYC_P)) u_auto_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_run(auto_run),
    .o_done(auto_done)
  );

  pfc_hold_timer #(.LIMIT(PWRUP_CYC_P)) u_pwrup_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_run(pwrup_run),
    .o_done(pwrup_done)
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      pwrup_pending <= 1'h1;
      gate_seen <= 1'h0;
    end
    else if (i_ce)
    begin
      if (pwrup_done)
        pwrup_pending <= 1'h0;
      if (gate_rise)
        gate_seen <= 1'h1;
    end
  end

  // ****************************************************************
  // output-enable state
  // ****************************************************************
  // while the power-up fault is pending only its own timer can clear it
  wire clear_ok = pwrup_pending ? pwrup_done : (enable_edge | auto_done);

  always_comb
  begin
    next_mode = mode;
    if (fault_evt)
      next_mode = ST_FAULT;
    else
    begin
      unique case (mode)
        ST_FAULT:
          if (clear_ok)
            next_mode = ST_IDLE;
        ST_IDLE:
          if (enable_edge && il_ok)
            next_mode = ST_ENABLED;
        ST_ENABLED:
          if (enable_edge)
            next_mode = ST_IDLE;
        default:
          next_mode = ST_FAULT;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      mode <= ST_FAULT;
    else if (i_ce)
      mode <= next_mode;
  end

  // ****************************************************************
  // overcurrent inhibit and gate rate check
  // ****************************************************************
  logic [OCW-1:0] oc_cnt;
  logic [PW-1:0] per_cnt;
  logic rate_err;

  wire oc_inhibit = (oc_cnt != '0);
  wire per_sat = (per_cnt == PW'(RATE_MIN_PERIOD_CYC_P));
  wire too_fast = gate_rise & ~per_sat;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      oc_cnt <= '0;
      per_cnt <= PW'(RATE_MIN_PERIOD_CYC_P);
      rate_err <= 1'h0;
    end
    else if (i_ce)
    begin
      if (oc_rise)
        oc_cnt <= OCW'(OC_INHIBIT_CYC_P);
      else if (oc_inhibit)
        oc_cnt <= oc_cnt - 1'h1;
      if (gate_rise)
      begin
        per_cnt <= '0;
        rate_err <= too_fast;
      end
      else if (!per_sat)
        per_cnt <= per_cnt + 1'h1;
    end
  end

  // ****************************************************************
  // gate path to the output stage
  // ****************************************************************
  logic ctrl_allow;
  wire eff_gate = pins.invert_n ? fast.gate : ~fast.gate;
  wire active = (mode == ST_ENABLED) & ~oc_inhibit & ~rate_err & ctrl_allow;
  wire drive_hi = active & eff_gate;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_drive_high <= 1'h0;
      o_drive_low <= 1'h1;
      o_led_enabled <= 1'h0;
      o_led_gated <= 1'h0;
      o_led_overcurrent <= 1'h0;
      o_led_rate_err <= 1'h0;
      o_fault <= 1'h1;
    end
    else if (i_ce)
    begin
      o_drive_high <= drive_hi;
      o_drive_low <= ~drive_hi;
      o_led_enabled <= (next_mode == ST_ENABLED);
      o_led_gated <= fast.gate;
      o_led_overcurrent <= oc_rise | (oc_cnt > OCW'(1));
      o_led_rate_err <= gate_rise ? too_fast : rate_err;
      o_fault <= (next_mode == ST_FAULT);
    end
  end

  // ****************************************************************
  // register slave
  // ****************************************************************
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  pfc_evt_type evt;
  pfc_state_type state_v;

  // a frozen clock enable must also hold the bus
  assign o_hreadyout = i_ce;
  assign o_hresp = 1'h0;

  wire addr_ok = i_hsel & i_hready & i_htrans[1];
  wire [ADDR_W-1:0] a_addr = i_haddr[ADDR_W-1:0];
  wire wr_ctrl = wr_pend & (wr_addr == REG_CTRL);
  wire wr_status = wr_pend & (wr_addr == REG_IRQ_STATUS);
  wire wr_mask = wr_pend & (wr_addr == REG_IRQ_MASK);
  wire [EVT_W-1:0] w1c = wr_status ? i_hwdata[EVT_W-1:0] : '0;

  assign evt = '{fault_set: fault_evt, fault_clr: (mode == ST_FAULT) & (next_mode == ST_IDLE),
                 enabled: (mode != ST_ENABLED) & (next_mode == ST_ENABLED), overcurrent: oc_rise,
                 rate_err: too_fast & ~rate_err};

  assign state_v = '{gate_seen: gate_seen, interlock_ok: il_ok, remote_mode: remote_mode, rate_err: rate_err,
                     oc_inhibit: oc_inhibit, pwrup_pending: pwrup_pending, fault_latched: (mode == ST_FAULT),
                     out_enabled: (mode == ST_ENABLED)};

  // new events win over a clear in the same cycle
  wire [EVT_W-1:0] next_irq_status = (irq_status & ~w1c) | evt;

  wire [31:0] rd_ctrl = {31'h0, ctrl_allow};
  wire [31:0] rd_state = {24'h0, state_v};
  wire [31:0] rd_status = {27'h0, irq_status};
  wire [31:0] rd_mask = {27'h0, irq_mask};
  wire [31:0] rd_val = (a_addr == REG_CTRL) ? rd_ctrl :
                       (a_addr == REG_STATE) ? rd_state :
                       (a_addr == REG_IRQ_STATUS) ? rd_status :
                       (a_addr == REG_IRQ_MASK) ? rd_mask : 32'h0;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      wr_pend <= 1'h0;
      wr_addr <= '0;
      o_hrdata <= 32'h0;
    end
    else if (i_ce)
    begin
      wr_pend <= addr_ok & i_hwrite;
      wr_addr <= a_addr;
      o_hrdata <= (addr_ok && !i_hwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_allow <= CTRL_ALLOW_RST;
      irq_mask <= IRQ_MASK_RST;
      irq_status <= '0;
      o_irq <= 1'h0;
    end
    else if (i_ce)
    begin
      if (wr_ctrl)
        ctrl_allow <= i_hwdata[CTRL_ALLOW_BIT];
      if (wr_mask)
        irq_mask <= i_hwdata[EVT_W-1:0];
      irq_status <= next_irq_status;
      o_irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule : pfc_ctrl

// file: pfc_ctrl_props.sv
// port-level checker for the pulser control top
// assumes the bench uses the shortened timer parameters
`timescale 1ns/10ps
module pfc_ctrl_props
  import pfc_pkg::*;
#(
  parameter int unsigned AUTOCLR_CYC_P = AUTOCLR_CYC
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_interlock_n,
  input wire logic i_autoclr_n,
  input wire logic i_overcurrent,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_drive_high,
  input wire logic o_drive_low,
  input wire logic o_led_enabled,
  input wire logic o_led_overcurrent,
  input wire logic o_fault
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // **********
  // fault run length while self-clear is selected
  // **********
  // a new fault inside the wait would restart the design timer, so only one is armed
  logic fault_q;
  logic arm;
  logic [31:0] run;
  always_ff @(posedge i_sys_clk)
  begin
    fault_q <= !i_rst_n || o_fault;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !o_fault || i_autoclr_n)
    begin
      arm <= 1'h0;
      run <= 32'h0;
    end
    else
    begin
      arm <= arm || !fault_q;
      run <= run + 32'h1;
    end
  end
  a_auto_clear_bound: assert property (arm |-> run <= AUTOCLR_CYC_P + 12)
    else $error("fault outlived self-clear time");
  a_hresp_okay: assert property (o_hresp == 1'h0)
    else $error("bus response not okay");
  a_ready_follows_ce: assert property (o_hreadyout == i_ce)
    else $error("ready differs from clock enable");
  a_rdata_idle_zero: assert property (i_ce && !(i_hsel && i_hready && i_htrans[1] && !i_hwrite) |=> o_hrdata == 32'h0)
    else $error("read data outside read data phase");
  a_drive_pair: assert property (o_drive_low == !o_drive_high)
    else $error("supply selects not complementary");
  a_drive_needs_en: assert property (o_drive_high |-> o_led_enabled || $past(o_led_enabled))
    else $error("output driven while not enabled");
  a_fault_blocks_en: assert property (o_fault |-> !o_led_enabled ##1 !o_drive_high)
    else $error("enabled while faulted");
  a_reset_state: assert property (disable iff (1'b0) !i_rst_n |=> o_fault && !o_led_enabled && !o_drive_high)
    else $error("reset state not faulted and off");
  a_oc_faults: assert property ($rose(i_overcurrent) |-> ##[1:12] (o_fault && o_led_overcurrent && !o_led_enabled))
    else $error("overcurrent did not fault and inhibit");
  a_lock_off: assert property (i_interlock_n [*8] |=> !o_led_enabled)
    else $error("enabled without interlock");
endmodule : pfc_ctrl_props

bind pfc_ctrl pfc_ctrl_props #(.AUTOCLR_CYC_P(AUTOCLR_CYC_P)) u_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_interlock_n(i_interlock_n), .i_autoclr_n(i_autoclr_n), .i_overcurrent(i_overcurrent),
  .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_drive_high(o_drive_high), .o_drive_low(o_drive_low),
  .o_led_enabled(o_led_enabled), .o_led_overcurrent(o_led_overcurrent), .o_fault(o_fault));

// file: pfc_remote_model.sv
// remote controller on the rear-panel control pins
// assumes debounce of a few cycles; pins change right after a rising edge
`timescale 1ns/10ps
module pfc_remote_model
(
  input wire logic i_sys_clk,
  output logic o_enable_n,
  output logic o_invert_n,
  output logic o_remote_n,
  output logic o_interlock_n,
  output logic o_autoclr_n
);
  // unwired pins sit at the pull-up level
  initial
  begin
    o_enable_n = 1'h1;
    o_invert_n = 1'h1;
    o_remote_n = 1'h1;
    o_interlock_n = 1'h1;
    o_autoclr_n = 1'h1;
  end
  task pins(input logic inv, input logic rem, input logic lock, input logic ac);
    o_invert_n <= inv;
    o_remote_n <= rem;
    o_interlock_n <= lock;
    o_autoclr_n <= ac;
  endtask : pins
  // low then released; a latched fault needs two of these
  task pulse_enable;
    o_enable_n <= 1'h0;
    repeat (6) @(posedge i_sys_clk);
    o_enable_n <= 1'h1;
    repeat (12) @(posedge i_sys_clk);
  endtask : pulse_enable
endmodule : pfc_remote_model

// file: test_pfc_ctrl.sv
// self-checking bench for the pulser control top
// assumes shortened timers; the bus master waits up to 20 cycles for hready, then fails the test
`timescale 1ns/10ps
module test_pfc_ctrl
  import pfc_pkg::*;
;
  localparam int AC = 50;
  localparam int PU = 100;
  localparam int OCI = 40;
  typedef struct { logic inv_n; logic g; logic dh; } pfc_row_type;
  pfc_row_type rows [4] = '{'{1'h1, 1'h0, 1'h0}, '{1'h1, 1'h1, 1'h1}, '{1'h0, 1'h0, 1'h1}, '{1'h0, 1'h1, 1'h0}};
  logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, press = 1'h0, gate = 1'h0, oc = 1'h0;
  logic hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  wire logic en_n, inv_n, rem_n, lock_n, ac_n, rdy, resp, dh, dl, len, lgate, loc, lrate, fault, irq;
  wire logic [31:0] hrdata;
  int fail_count = 0, num_checks = 0;
  always #25 clk = ~clk;
  pfc_remote_model rem (.i_sys_clk(clk), .o_enable_n(en_n), .o_invert_n(inv_n), .o_remote_n(rem_n),
    .o_interlock_n(lock_n), .o_autoclr_n(ac_n));
  pfc_ctrl #(.AUTOCLR_CYC_P(AC), .PWRUP_CYC_P(PU), .OC_INHIBIT_CYC_P(OCI), .RATE_MIN_PERIOD_CYC_P(8),
    .DEBOUNCE_CYC_P(2)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_enable_n(en_n),
    .i_invert_n(inv_n), .i_remote_n(rem_n), .i_interlock_n(lock_n), .i_autoclr_n(ac_n), .i_panel_press(press),
    .i_gate(gate), .i_overcurrent(oc), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata),
    .o_drive_high(dh), .o_drive_low(dl), .o_led_enabled(len), .o_led_gated(lgate), .o_led_overcurrent(loc),
    .o_led_rate_err(lrate), .o_fault(fault), .o_irq(irq));
  // **********
  // helpers
  // **********
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task chk(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t %s got %b want %b", $time, m, g, e);
    end
  endtask : chk
  task chkw(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chkw
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (rdy !== 1'h1)
    begin
      n++;
      if (n > 20)
      begin
        fail_count++;
        $display("BAD %0t bus hang", $time);
        results();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // whole-word single transfer; read data taken at the data-phase edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus
  task push;
    press <= 1'h1;
    step(8);
    press <= 1'h0;
    step(10);
  endtask : push
  // **********
  // main sequence
  // **********
  initial
  begin
    step(8);
    chk(fault, 1'h1, "reset fault");
    chk(len, 1'h0, "reset enabled");
    rst_n <= 1'h1;
    step(2);
    bus(1'h0, REG_CTRL, 32'h0);
    chkw(q, 32'h1, "ctrl reset");
    bus(1'h0, REG_IRQ_MASK, 32'h0);
    chkw(q, 32'h0, "mask reset");
    bus(1'h0, 8'h10, 32'h0);
    chkw(q, 32'h0, "unmapped");
    rem.pins(1'h1, 1'h1, 1'h0, 1'h1);
    step(12);
    rem.pulse_enable();
    chk(len, 1'h0, "enable in power-up fault");
    gate <= 1'h1;
    step(10);
    gate <= 1'h0;
    step(PU + 10);
    chk(fault, 1'h0, "power-up fault cleared");
    chk(len, 1'h0, "no auto enable");
    $display("test power-up done");
    rem.pins(1'h1, 1'h0, 1'h0, 1'h1);
    push();
    chk(len, 1'h0, "panel in remote");
    rem.pulse_enable();
    chk(len, 1'h1, "pin enable in remote");
    rem.pulse_enable();
    chk(len, 1'h0, "pin disables");
    rem.pins(1'h1, 1'h1, 1'h0, 1'h1);
    step(12);
    push();
    chk(len, 1'h1, "panel enable local");
    $display("test enable sources done");
    for (int i = 0; i < 4; i++)
    begin
      rem.pins(rows[i].inv_n, 1'h1, 1'h0, 1'h1);
      gate <= rows[i].g;
      step(12);
      chk(dh, rows[i].dh, "drive high");
      chk(dl, !rows[i].dh, "drive low");
      chk(lgate, rows[i].g, "gated led");
    end
    rem.pins(1'h1, 1'h1, 1'h0, 1'h1);
    gate <= 1'h1;
    step(12);
    bus(1'h1, REG_CTRL, 32'h0);
    step(2);
    chk(dh, 1'h0, "allow cleared");
    bus(1'h1, REG_CTRL, 32'h1);
    $display("test gate rows done");
    bus(1'h1, REG_IRQ_STATUS, 32'h1F);
    bus(1'h1, REG_IRQ_MASK, 32'h1);
    step(2);
    chk(irq, 1'h0, "irq idle");
    chk(dh, 1'h1, "allow restored");
    oc <= 1'h1;
    step(20);
    oc <= 1'h0;
    chk(fault, 1'h1, "oc fault");
    chk(len, 1'h0, "oc disables");
    chk(loc, 1'h1, "oc led");
    chk(dh, 1'h0, "oc inhibits");
    chk(irq, 1'h1, "irq raised");
    step(OCI);
    chk(loc, 1'h0, "oc inhibit ends");
    step(AC + 20);
    chk(fault, 1'h1, "fault latched");
    bus(1'h0, REG_IRQ_STATUS, 32'h0);
    chkw(q & 32'h9, 32'h9, "status fault and oc");
    bus(1'h1, REG_IRQ_STATUS, 32'h1);
    step(2);
    chk(irq, 1'h0, "irq cleared");
    rem.pulse_enable();
    chk(fault, 1'h0, "first pulse clears");
    chk(len, 1'h0, "first pulse no enable");
    rem.pulse_enable();
    chk(len, 1'h1, "second pulse enables");
    $display("test overcurrent done");
    rem.pins(1'h1, 1'h1, 1'h0, 1'h0);
    step(12);
    rem.pins(1'h1, 1'h1, 1'h1, 1'h0);
    step(12);
    chk(fault, 1'h1, "interlock loss fault");
    step(AC);
    chk(fault, 1'h0, "self-clear");
    rem.pulse_enable();
    chk(len, 1'h0, "enable without interlock");
    rem.pins(1'h1, 1'h1, 1'h0, 1'h1);
    step(12);
    rem.pulse_enable();
    chk(len, 1'h1, "enable with interlock");
    $display("test interlock done");
    repeat (8)
    begin
      gate <= 1'h0;
      step(2);
      gate <= 1'h1;
      step(2);
    end
    step(4);
    chk(lrate, 1'h1, "rate error");
    chk(dh, 1'h0, "rate inhibits");
    gate <= 1'h0;
    step(12);
    gate <= 1'h1;
    step(12);
    chk(lrate, 1'h0, "rate recovers");
    chk(dh, 1'h1, "drive resumes");
    $display("test rate done");
    ce <= 1'h0;
    gate <= 1'h0;
    step(12);
    chk(rdy, 1'h0, "ready held by ce");
    chk(dh, 1'h1, "drive frozen");
    ce <= 1'h1;
    step(12);
    chk(dh, 1'h0, "drive after thaw");
    $display("test clock enable done");
    rst_n <= 1'h0;
    step(2);
    rst_n <= 1'h1;
    step(1);
    chk(fault, 1'h1, "second reset fault");
    chk(dh, 1'h0, "second reset drive");
    $display("test second reset done");
    results();
  end
endmodule : test_pfc_ctrl
